// >>> verilog/sfrb3_pkg.sv
// sfrb3_pkg: offsets, field positions, reset values of the upper register bank.
// assumes a 9-bit data-memory address from the core and 8-bit data.
package sfrb3_pkg;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam logic [8:0] OFS_INDIRECT_DATA = 9'h180;
  localparam logic [8:0] OFS_OPTION = 9'h181;
  localparam logic [8:0] OFS_PC_LOW = 9'h182;
  localparam logic [8:0] OFS_FLAGS = 9'h183;
  localparam logic [8:0] OFS_POINTER = 9'h184;
  localparam logic [8:0] OFS_DIR_B = 9'h186;
  localparam logic [8:0] OFS_DIR_F = 9'h187;
  localparam logic [8:0] OFS_DIR_G = 9'h188;
  localparam logic [8:0] OFS_PC_HIGH = 9'h18a;
  localparam logic [8:0] OFS_INT_CTRL = 9'h18b;
  // processor_flags field positions
  localparam int unsigned BIT_CARRY = 0;
  localparam int unsigned BIT_DIGIT = 1;
  localparam int unsigned BIT_ZERO = 2;
  localparam int unsigned BIT_PDOWN = 3;
  localparam int unsigned BIT_WDTO = 4;
  localparam int unsigned BIT_RP0 = 5;
  localparam int unsigned BIT_RP1 = 6;
  localparam int unsigned BIT_IRP = 7;
  localparam logic [7:0] FLAGS_ALU_MASK = 8'h07;
  localparam logic [7:0] FLAGS_RESET_MASK = 8'h18;
  localparam logic [7:0] FLAGS_WRITE_MASK = 8'he0;
  localparam logic [7:0] FLAGS_POR = 8'h18;
  localparam logic [7:0] PC_HIGH_MASK = 8'h1f;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_PC_LOW = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_PC_HIGH = 8'h00;
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

// >>> verilog/sfrb3_flag_unit.sv
// sfrb3_flag_unit: next value of the processor flags register.
// assumes the core presents alu flags in the same cycle as the write.
`timescale 1ns/1ns
module sfrb3_flag_unit
(
  input wire logic [7:0] i_cur,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_alu_upd,
  input wire logic i_alu_zero,
  input wire logic i_alu_digit,
  input wire logic i_alu_carry,
  input wire logic i_subtract,
  input wire logic i_rst_cause_ld,
  input wire logic i_wdto_val,
  input wire logic i_pdown_val,
  output logic [7:0] o_next
);
  logic [7:0] wr_val;
  logic [7:0] alu_val;
  logic [7:0] cause_val;
  logic dig_out;
  logic car_out;

  // subtraction reports borrow as active low
  assign dig_out = i_subtract ? ~i_alu_digit : i_alu_digit;
  assign car_out = i_subtract ? ~i_alu_carry : i_alu_carry;

  // instruction writes reach the bank-select bits here and the alu flag bits below; reset cause bits locked
  assign wr_val = i_wr ?
    ((i_cur & ~sfrb3_pkg::FLAGS_WRITE_MASK) | (i_wdata & sfrb3_pkg::FLAGS_WRITE_MASK)) :
    i_cur;
  // alu update of the three flags overrides a data write to them
  assign alu_val = i_alu_upd ? {wr_val[7:3], i_alu_zero, dig_out, car_out} :
    (i_wr ? {wr_val[7:3], i_wdata[2:0]} : wr_val);
  assign cause_val = i_rst_cause_ld ?
    {alu_val[7:5], i_wdto_val, i_pdown_val, alu_val[2:0]} : alu_val;
  assign o_next = cause_val;
endmodule

// >>> verilog/sfrb3_bank.sv
// sfrb3_bank: upper special register bank with status write guard.
// assumes a single-cycle core data access on the instruction clock.
//
// Summary of operation
// - one register holds alu, reset, bank bits
// - flags register writable except its reset-cause bits
// - alu flag update overrides data write
// - reset-cause bits ignore instruction writes
// - clear-file zeroes top bits, sets zero
// - subtraction carries are active-low borrows
// - unimplemented addresses and bits read zero
`timescale 1ns/1ns
module sfrb3_bank
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [8:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_alu_upd,
  input wire logic i_alu_zero,
  input wire logic i_alu_digit,
  input wire logic i_alu_carry,
  input wire logic i_subtract,
  input wire logic i_rst_cause_ld,
  input wire logic i_wdto_val,
  input wire logic i_pdown_val,
  output logic o_ind_rd,
  output logic o_ind_wr,
  output logic [7:0] o_ind_addr,
  output logic [7:0] o_ind_wdata,
  input wire logic [7:0] i_ind_rdata,
  output logic [7:0] o_flags,
  output logic [7:0] o_option,
  output logic [7:0] o_pc_low,
  output logic [4:0] o_pc_high,
  output logic [7:0] o_dir_b,
  output logic [7:0] o_dir_f,
  output logic [7:0] o_dir_g,
  output logic [7:0] o_int_ctrl
);
  ////////////////////////////////////////////////////////////////////////////
  // port direction registers b, f and g, in that order
  localparam int unsigned DIR_N = 3;

  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] option_reg;
  logic [7:0] option_next;
  logic [7:0] pc_low_reg;
  logic [7:0] pc_low_next;
  logic [7:0] pointer_reg;
  logic [7:0] pointer_next;
  logic [7:0] dir_reg [DIR_N];
  logic [7:0] dir_next [DIR_N];
  logic [7:0] pc_high_reg;
  logic [7:0] pc_high_next;
  logic [7:0] int_ctrl_reg;
  logic [7:0] int_ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic sel_ind;
  logic sel_opt;
  logic sel_pcl;
  logic sel_flg;
  logic sel_ptr;
  logic sel_db;
  logic sel_df;
  logic sel_dg;
  logic sel_pch;
  logic sel_int;
  logic [DIR_N-1:0] sel_dir;
  logic wr_opt;
  logic wr_pcl;
  logic wr_ptr;
  logic wr_pch;
  logic wr_int;
  logic [DIR_N-1:0] wr_dir;
  logic [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  assign sel_ind = (i_addr == sfrb3_pkg::OFS_INDIRECT_DATA);
  assign sel_opt = (i_addr == sfrb3_pkg::OFS_OPTION);
  assign sel_pcl = (i_addr == sfrb3_pkg::OFS_PC_LOW);
  assign sel_flg = (i_addr == sfrb3_pkg::OFS_FLAGS);
  assign sel_ptr = (i_addr == sfrb3_pkg::OFS_POINTER);
  assign sel_db = (i_addr == sfrb3_pkg::OFS_DIR_B);
  assign sel_df = (i_addr == sfrb3_pkg::OFS_DIR_F);
  assign sel_dg = (i_addr == sfrb3_pkg::OFS_DIR_G);
  assign sel_pch = (i_addr == sfrb3_pkg::OFS_PC_HIGH);
  assign sel_int = (i_addr == sfrb3_pkg::OFS_INT_CTRL);
  assign sel_dir = {sel_dg, sel_df, sel_db};

  // write strobes per register; writes off the map are dropped
  assign wr_opt = i_wr & sel_opt;
  assign wr_pcl = i_wr & sel_pcl;
  assign wr_ptr = i_wr & sel_ptr;
  assign wr_pch = i_wr & sel_pch;
  assign wr_int = i_wr & sel_int;
  assign wr_dir = sel_dir & {DIR_N{i_wr}};

  assign option_next = wr_opt ? i_wdata : option_reg;
  assign pc_low_next = wr_pcl ? i_wdata : pc_low_reg;
  assign pointer_next = wr_ptr ? i_wdata : pointer_reg;
  // upper latch bits are masked off on write and read, so they can never read back set
  assign pc_high_next = wr_pch ? (i_wdata & sfrb3_pkg::PC_HIGH_MASK) : pc_high_reg;
  assign int_ctrl_next = wr_int ? i_wdata : int_ctrl_reg;
  // captured on reads only, so a result stands until the next read
  assign rdata_next = i_rd ? rd_mux : rdata_reg;

  // no storage behind the indirect port; the pointer picks the byte
  assign o_ind_rd = i_rd & sel_ind;
  assign o_ind_wr = i_wr & sel_ind;
  assign o_ind_addr = pointer_reg;
  assign o_ind_wdata = i_wdata;

  // clear-file: the core writes zero, flags a zero result and echoes the
  // current digit and carry flags, so the guard yields 000u u1uu
  sfrb3_flag_unit u_flags
  (
    .i_cur(flags_reg),
    .i_wdata(i_wdata),
    .i_wr(i_wr & sel_flg),
    .i_alu_upd(i_alu_upd),
    .i_alu_zero(i_alu_zero),
    .i_alu_digit(i_alu_digit),
    .i_alu_carry(i_alu_carry),
    .i_subtract(i_subtract),
    .i_rst_cause_ld(i_rst_cause_ld),
    .i_wdto_val(i_wdto_val),
    .i_pdown_val(i_pdown_val),
    .o_next(flags_next)
  );

  assign rd_mux =
    sel_ind ? i_ind_rdata :
    sel_opt ? option_reg :
    sel_pcl ? pc_low_reg :
    sel_flg ? flags_reg :
    sel_ptr ? pointer_reg :
    sel_db ? dir_reg[0] :
    sel_df ? dir_reg[1] :
    sel_dg ? dir_reg[2] :
    sel_pch ? (pc_high_reg & sfrb3_pkg::PC_HIGH_MASK) :
    sel_int ? int_ctrl_reg :
    sfrb3_pkg::READ_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      flags_reg <= sfrb3_pkg::FLAGS_POR;
    else
      flags_reg <= flags_next;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      option_reg <= sfrb3_pkg::RST_OPTION;
    else
      option_reg <= option_next;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pc_low_reg <= sfrb3_pkg::RST_PC_LOW;
    else
      pc_low_reg <= pc_low_next;
  end

  // pointer reset is a free choice; software loads it before use
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pointer_reg <= sfrb3_pkg::RST_POINTER;
    else
      pointer_reg <= pointer_next;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pc_high_reg <= sfrb3_pkg::RST_PC_HIGH;
    else
      pc_high_reg <= pc_high_next;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      int_ctrl_reg <= sfrb3_pkg::RST_INT_CTRL;
    else
      int_ctrl_reg <= int_ctrl_next;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rdata_reg <= sfrb3_pkg::READ_ZERO;
    else
      rdata_reg <= rdata_next;
  end

  // one write path serves every port direction register
  for (genvar n = 0; n < DIR_N; n++)
  begin : g_dir
    assign dir_next[n] = wr_dir[n] ? i_wdata : dir_reg[n];
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
      if (!i_rst_b)
        dir_reg[n] <= sfrb3_pkg::RST_DIR;
      else
        dir_reg[n] <= dir_next[n];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_rdata = rdata_reg;
  assign o_flags = flags_reg;
  assign o_option = option_reg;
  assign o_pc_low = pc_low_reg;
  assign o_pc_high = pc_high_reg[4:0];
  assign o_dir_b = dir_reg[0];
  assign o_dir_f = dir_reg[1];
  assign o_dir_g = dir_reg[2];
  assign o_int_ctrl = int_ctrl_reg;
endmodule

// >>> sim/sfrb3_bank_assertions.sv
// port checker for sfrb3_bank
// assumes a bind to sfrb3_bank, ports matched by name
`timescale 1ns/1ns
module sfrb3_bank_assertions
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [8:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic i_alu_upd,
  input wire logic i_alu_zero,
  input wire logic i_alu_digit,
  input wire logic i_alu_carry,
  input wire logic i_subtract,
  input wire logic i_rst_cause_ld,
  input wire logic [7:0] i_ind_rdata,
  input wire logic o_ind_rd,
  input wire logic [7:0] o_ind_addr,
  input wire logic [7:0] o_flags
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire st_wr = i_wr && i_addr == 9'h183;
  wire hole = i_addr inside {9'h185, 9'h189, [9'h18c:9'h19f]};
  property p_tdp; !i_rst_cause_ld |=> $stable(o_flags[4:3]); endproperty
  a_tdp: assert property (p_tdp) else $error("reset-cause bits moved");
  property p_top; st_wr |=> o_flags[7:5] == $past(i_wdata[7:5]); endproperty
  a_top: assert property (p_top) else $error("bank bits not written");
  property p_low; st_wr && !i_alu_upd |=> o_flags[2:0] == $past(i_wdata[2:0]); endproperty
  a_low: assert property (p_low) else $error("plain flag write lost");
  property p_zero; i_alu_upd |=> o_flags[2] == $past(i_alu_zero); endproperty
  a_zero: assert property (p_zero) else $error("zero flag not from alu");
  property p_alu; i_alu_upd |=> o_flags[1:0] ==
    ({$past(i_alu_digit), $past(i_alu_carry)} ^ {2{$past(i_subtract)}}); endproperty
  a_alu: assert property (p_alu) else $error("carry flags wrong");
  property p_ind; o_ind_rd == (i_rd && i_addr == 9'h180); endproperty
  a_ind: assert property (p_ind) else $error("indirect read strobe wrong");
  property p_ird; i_rd && i_addr == 9'h180 |=> o_rdata == $past(i_ind_rdata); endproperty
  a_ird: assert property (p_ird) else $error("indirect data wrong");
  property p_ptr; i_wr && i_addr == 9'h184 |=> o_ind_addr == $past(i_wdata); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not loaded");
  property p_hole; i_rd && hole |=> o_rdata == 8'h00; endproperty
  a_hole: assert property (p_hole) else $error("hole read not zero");
  c_guard: cover property (st_wr && i_alu_upd);
  c_sub: cover property (i_alu_upd && i_subtract);
  c_hole: cover property (i_rd && hole);
endmodule

// >>> sim/sfrb3_mem_model.sv
// data memory behind the indirect port
// assumes one byte access per cycle from the bank
`timescale 1ns/1ns
module sfrb3_mem_model
(
  input wire logic i_clock,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [256];
  initial foreach (mem[k]) mem[k] = 8'h00;
  // unselected: no stale byte on the bus
  assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];
  always @(posedge i_clock) if (i_wr) mem[i_addr] <= i_wdata;
endmodule

// >>> sim/testbench.sv
// self-checking bench for sfrb3_bank
// assumes sfrb3_mem_model answers indirect accesses
`timescale 1ns/1ns
module testbench;
  logic i_clock = 0, i_rst_b = 0, i_rd = 0, i_wr = 0, i_alu_upd = 0, i_alu_zero = 0;
  logic i_alu_digit = 0, i_alu_carry = 0, i_subtract = 0, i_rst_cause_ld = 0;
  logic i_wdto_val = 0, i_pdown_val = 0;
  logic [8:0] i_addr = 0;
  logic [7:0] i_wdata = 0, mf, pf, rm [32], mm [256];
  logic [16:0] lf = 17'h17455;
  localparam logic [15:0] IMP = 16'h0dd6;
  wire [7:0] o_rdata, o_ind_addr, o_ind_wdata, i_ind_rdata, o_flags, o_option, o_pc_low;
  wire [7:0] o_dir_b, o_dir_f, o_dir_g, o_int_ctrl;
  wire [4:0] o_pc_high;
  wire o_ind_rd, o_ind_wr;
  int fail_count = 0, check_count = 0;
  always #50 i_clock = ~i_clock;
  sfrb3_bank sfrb3_bank_i (.*);
  sfrb3_mem_model sfrb3_mem_model_i (.i_clock(i_clock), .i_rd(o_ind_rd), .i_wr(o_ind_wr),
    .i_addr(o_ind_addr), .i_wdata(o_ind_wdata), .o_rdata(i_ind_rdata));
  ////////////////////////////////////////////////////////////////////////////
  function logic [7:0] rnd();
    lf = {lf[15:0], lf[16] ^ lf[13]};
    return lf[7:0];
  endfunction
  task chk(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t mismatch %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task rst();
    @(negedge i_clock);
    i_rst_b = 0;
    // idle strobes, so no stale write lands on the edge after release
    {i_rd, i_wr, i_alu_upd, i_rst_cause_ld} = 4'h0;
    repeat (2) @(negedge i_clock);
    i_rst_b = 1;
    mf = 8'h18;
    foreach (rm[k]) rm[k] = k inside {1, 6, 7, 8} ? 8'hff : 8'h00;
  endtask
  // g = {cause load, timeout, power-down, alu update, subtract, zero, digit, carry}
  task cyc(input logic [8:0] a, input logic r, w, input logic [7:0] d, g);
    logic [7:0] e;
    @(negedge i_clock);
    {i_addr, i_rd, i_wr, i_wdata} = {a, r, w, d};
    {i_rst_cause_ld, i_wdto_val, i_pdown_val, i_alu_upd, i_subtract, i_alu_zero,
      i_alu_digit, i_alu_carry} = g;
    e = a == 9'h183 ? mf : a == 9'h180 ? mm[rm[4]] : rm[a[4:0]];
    @(posedge i_clock);
    if (w && a == 9'h183) mf = (mf & 8'h18) | (d & 8'he7);
    if (g[4]) mf[2:0] = {g[2], g[1:0] ^ {2{g[3]}}};
    if (g[7]) mf[4:3] = g[6:5];
    if (w && a == 9'h180) mm[rm[4]] = d;
    if (w && a[8:4] == 5'h18 && IMP[a[3:0]]) rm[a[3:0]] = d & (a[3:0] == 10 ? 8'h1f : 8'hff);
    #1;
    if (r) chk(o_rdata, e);
    chk(o_flags, mf);
    chk(o_option, rm[1]);
    chk(o_pc_low, rm[2]);
    chk(o_ind_addr, rm[4]);
    chk(o_dir_b, rm[6]);
    chk(o_dir_f, rm[7]);
    chk(o_dir_g, rm[8]);
    chk({3'b000, o_pc_high}, rm[10]);
    chk(o_int_ctrl, rm[11]);
    chk(o_ind_wdata, d);
    chk({o_ind_rd, o_ind_wr, 6'h00}, {r && a == 9'h180, w && a == 9'h180, 6'h00});
  endtask
  task scan();
    for (int k = 0; k < 32; k++) cyc(9'(9'h180 + k), 1, 0, 8'h00, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    foreach (mm[k]) mm[k] = 8'h00;
    rst();
    scan();
    repeat (3)
      for (int k = 0; k < 32; k++)
      begin
        cyc(9'(9'h180 + k), 0, 1, rnd(), 8'h00);
        cyc(9'(9'h180 + k), 1, 0, 8'h00, 8'h00);
      end
    repeat (40)
    begin
      cyc(9'h183, 0, rnd() > 8'h80, rnd(), rnd());
      cyc(9'h183, 1, 0, 8'h00, 8'h00);
    end
    cyc(9'h18a, 0, 1, rnd() & 8'h1f, 8'h00);
    cyc(9'h18a, 1, 0, 8'h00, 8'h00);
    // clear-file: zero write, zero result, digit and carry echoed by the core
    pf = mf;
    cyc(9'h183, 0, 1, 8'h00, {6'b000101, mf[1:0]});
    chk(o_flags, {3'b000, pf[4:3], 1'b1, pf[1:0]});
    rst();
    scan();
    finish_test();
  end
  initial
  begin
    repeat (3000) @(posedge i_clock);
    fail_count++;
    finish_test();
  end
endmodule
bind sfrb3_bank sfrb3_bank_assertions sfrb3_bank_assertions_i (.*);
